// file: rtl/status_out_pkg.sv
// Constants for the configurable status output logic
package status_out_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DELAY_MAX_S   = 100;
  localparam int unsigned DELAY_MAX     = DELAY_MAX_S * 1000 / TICK_MS;
  localparam int unsigned DELAY_W       = 10;

  localparam logic [7:0] ADDR_FUNC_SEL  = 8'h00;
  localparam logic [7:0] ADDR_POLARITY  = 8'h04;
  localparam logic [7:0] ADDR_A_ON_DLY  = 8'h08;
  localparam logic [7:0] ADDR_A_OFF_DLY = 8'h0c;
  localparam logic [7:0] ADDR_B_ON_DLY  = 8'h10;
  localparam logic [7:0] ADDR_B_OFF_DLY = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;

  localparam int unsigned FSEL_A_LSB    = 0;
  localparam int unsigned FSEL_B_LSB    = 8;
  localparam int unsigned POL_A_LSB     = 0;
  localparam int unsigned POL_B_LSB     = 8;

  localparam logic [3:0] FUNC_RUN        = 4'h0;
  localparam logic [3:0] FUNC_FREQ_REACH = 4'h1;
  localparam logic [3:0] FUNC_FREQ_THR   = 4'h2;
  localparam logic [3:0] FUNC_OVERLOAD   = 4'h3;
  localparam logic [3:0] FUNC_PID_DEV    = 4'h4;
  localparam logic [3:0] FUNC_FAULT      = 4'h5;
  localparam logic [3:0] FUNC_SP_LOST    = 4'h6;
  localparam logic [3:0] FUNC_FB_BREACH  = 4'h7;
  localparam logic [3:0] FUNC_WATCHDOG   = 4'h8;
  localparam logic [3:0] FUNC_LOGIC_LINK = 4'h9;
  localparam logic [3:0] FUNC_FIELDBUS   = 4'ha;
  localparam logic [3:0] FUNC_LAST       = 4'ha;

  localparam logic [3:0] FSEL_A_RESET    = 4'h1;
  localparam logic [3:0] FSEL_B_RESET    = 4'h0;
  localparam logic [1:0] POL_MAKE        = 2'h0;
  localparam logic [1:0] POL_BREAK       = 2'h1;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_ON_WAIT = 2'b01,
    ST_ON      = 2'b11,
    ST_OFF_WAIT = 2'b10
  } dly_state_t;
endpackage : status_out_pkg

// file: rtl/status_out.sv
// Two configurable status outputs with APB register access
//
// Operation
// - Per-output function code; 01 selects freq reached, 00 selects running.
// - Code 02: frequency above accel/decel threshold while ramping.
// - Code 03: motor current above overload warning threshold.
// - Code 04: PID deviation above signalling threshold.
// - Code 05: drive in fault or alarm state.
// - Code 06: voltage setpoint below minimum or current below 4 mA.
// - Code 07: PID feedback outside upper or lower limit.
// - Code 08: serial watchdog expired, per watchdog configuration.
// - Code 09: logic-link result; code 10: fieldbus overload or interruption.
// - Default make contact: output active when condition active.
// - Polarity 00 make, 01 break; 00 after reset.
// - Separate on-delay and off-delay per output, 0 to 100 s.
// - Condition dropping before on-delay ends never switches output on.
// - Once on, output holds for full off-delay after condition drops.
`timescale 1ns/100ps
`default_nettype none
module status_out
  import status_out_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
)(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_running,
  input  wire logic        i_freq_setpoint_reached,
  input  wire logic        i_freq_threshold_exceeded,
  input  wire logic        i_overload_warning,
  input  wire logic        i_pid_deviation_alarm,
  input  wire logic        i_fault_alarm,
  input  wire logic        i_setpoint_signal_lost,
  input  wire logic        i_pid_feedback_limit_breach,
  input  wire logic        i_comm_watchdog_expired,
  input  wire logic        i_logic_link_result,
  input  wire logic        i_fieldbus_comm_overload,
  output logic             o_out_a,
  output logic             o_out_b
);
  logic [3:0]         fsel_q [2];
  logic               pol_q [2];
  logic [DELAY_W-1:0] on_dly_q [2];
  logic [DELAY_W-1:0] off_dly_q [2];
  logic [23:0]        div_q;
  logic               tick_q;
  logic [10:0]        cond_vec;
  logic [1:0]         cond;
  logic [1:0]         out_raw;
  logic               wr_en;
  logic               acc;
  logic               lock_q;

  assign acc   = psel && penable;
  assign wr_en = acc && pwrite;

  // Inputs come from same-clock status generators, so no synchroniser
  assign cond_vec = {i_fieldbus_comm_overload,
                     i_logic_link_result,
                     i_comm_watchdog_expired,
                     i_pid_feedback_limit_breach,
                     i_setpoint_signal_lost,
                     i_fault_alarm,
                     i_pid_deviation_alarm,
                     i_overload_warning,
                     i_freq_threshold_exceeded,
                     i_freq_setpoint_reached,
                     i_running};

  // Codes above the last function select nothing
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      cond[k] = (fsel_q[k] <= FUNC_LAST) ? cond_vec[fsel_q[k]] : 1'b0;
    end
  end

  // 0.1 s step enable
  // Free-running phase, so a setting of N steps lasts N-1 to N steps
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_q  <= 24'h000000;
      tick_q <= 1'b0;
    end
    else if (div_q == 24'(TICK_CYC - 1))
    begin
      div_q  <= 24'h000000;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // Function select, locked while running
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fsel_q[0] <= FSEL_A_RESET;
      fsel_q[1] <= FSEL_B_RESET;
    end
    else if (wr_en && paddr == ADDR_FUNC_SEL && !lock_q)
    begin
      fsel_q[0] <= pwdata[FSEL_A_LSB +: 4];
      fsel_q[1] <= pwdata[FSEL_B_LSB +: 4];
    end
  end

  // Running sampled at setup, so the refusal and pslverr always agree
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lock_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      lock_q <= i_running;
    end
  end

  // Polarity takes effect on the next output update
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pol_q[0] <= 1'b0;
      pol_q[1] <= 1'b0;
    end
    else if (wr_en && paddr == ADDR_POLARITY)
    begin
      pol_q[0] <= pwdata[POL_A_LSB];
      pol_q[1] <= pwdata[POL_B_LSB];
    end
  end

  // Delays saturate at 100 s
  // A timer already running keeps the count it loaded
  function automatic logic [DELAY_W-1:0] clip(input logic [31:0] v);
    clip = (v > 32'(DELAY_MAX)) ? DELAY_W'(DELAY_MAX) : v[DELAY_W-1:0];
  endfunction : clip

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      on_dly_q[0]  <= '0;
      on_dly_q[1]  <= '0;
      off_dly_q[0] <= '0;
      off_dly_q[1] <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_A_ON_DLY:  on_dly_q[0]  <= clip(pwdata);
        ADDR_A_OFF_DLY: off_dly_q[0] <= clip(pwdata);
        ADDR_B_ON_DLY:  on_dly_q[1]  <= clip(pwdata);
        ADDR_B_OFF_DLY: off_dly_q[1] <= clip(pwdata);
        default: ;
      endcase
    end
  end

  // One delay machine per output
  for (genvar g = 0; g < 2; g++)
  begin : g_dly
    dly_state_t         st_q;
    logic [DELAY_W-1:0] cnt_q;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        st_q  <= ST_OFF;
        cnt_q <= '0;
      end
      else
      begin
        unique case (st_q)
          ST_OFF:
          begin
            // Zero on-delay goes straight on
            if (cond[g])
            begin
              cnt_q <= on_dly_q[g];
              st_q  <= (on_dly_q[g] == '0) ? ST_ON : ST_ON_WAIT;
            end
          end
          ST_ON_WAIT:
          begin
            // A condition pulse shorter than the on-delay is swallowed here
            if (!cond[g])
            begin
              st_q <= ST_OFF;
            end
            else if (cnt_q == '0)
            begin
              st_q <= ST_ON;
            end
            else if (tick_q)
            begin
              cnt_q <= cnt_q - DELAY_W'(1);
            end
          end
          ST_ON:
          begin
            // Off-delay loaded only when the condition falls
            if (!cond[g])
            begin
              cnt_q <= off_dly_q[g];
              st_q  <= (off_dly_q[g] == '0) ? ST_OFF : ST_OFF_WAIT;
            end
          end
          ST_OFF_WAIT:
          begin
            // Condition returning does not cut the off-delay short
            if (cnt_q == '0)
            begin
              st_q <= ST_OFF;
            end
            else if (tick_q)
            begin
              cnt_q <= cnt_q - DELAY_W'(1);
            end
          end
        endcase
      end
    end

    // Output still held during the off-delay
    assign out_raw[g] = (st_q == ST_ON) || (st_q == ST_OFF_WAIT);
  end

  // Output high means transistor conducts to the common reference
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_out_a <= 1'b0;
      o_out_b <= 1'b0;
    end
    else
    begin
      o_out_a <= out_raw[0] ^ pol_q[0];
      o_out_b <= out_raw[1] ^ pol_q[1];
    end
  end

  // APB: one wait-free answer in the access cycle
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      unique case (paddr)
        ADDR_FUNC_SEL:  prdata <= {20'h00000, fsel_q[1], 4'h0, fsel_q[0]};
        ADDR_POLARITY:  prdata <= {23'h000000, pol_q[1], 7'h00, pol_q[0]};
        ADDR_A_ON_DLY:  prdata <= {22'h000000, on_dly_q[0]};
        ADDR_A_OFF_DLY: prdata <= {22'h000000, off_dly_q[0]};
        ADDR_B_ON_DLY:  prdata <= {22'h000000, on_dly_q[1]};
        ADDR_B_OFF_DLY: prdata <= {22'h000000, off_dly_q[1]};
        ADDR_STATUS:    prdata <= {28'h0000000, out_raw, cond};
        default:        pslverr <= 1'b1;
      endcase
      // Same running sample as the write lock
      if (pwrite && paddr == ADDR_FUNC_SEL && i_running)
        pslverr <= 1'b1;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : status_out
`default_nettype wire

// file: verif/relay_load.sv
// Relay coils hung on the two status outputs
`timescale 1ns/100ps
`default_nettype none
module relay_load (
  input  wire logic i_core_clk,
  input  wire logic i_coil_a,
  input  wire logic i_coil_b,
  output logic      o_contact_a,
  output logic      o_contact_b
);
  // Armature picks up a clock late, so a one-cycle glitch would show
  always_ff @(posedge i_core_clk)
    {o_contact_b, o_contact_a} <= {i_coil_b, i_coil_a};
endmodule : relay_load
`default_nettype wire

// file: verif/status_out_properties.sv
// Port-level assertions for the status output block
`timescale 1ns/100ps
`default_nettype none
module status_out_properties
  import status_out_pkg::*;
(
  input wire logic        i_core_clk, i_rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata, pwdata,
  input wire logic        i_running, i_freq_setpoint_reached, i_freq_threshold_exceeded,
  input wire logic        i_overload_warning, i_pid_deviation_alarm, i_fault_alarm,
  input wire logic        i_setpoint_signal_lost, i_pid_feedback_limit_breach,
  input wire logic        i_comm_watchdog_expired, i_logic_link_result, i_fieldbus_comm_overload,
  input wire logic        o_out_a, o_out_b
);
  wire logic [10:0] cv = {i_fieldbus_comm_overload, i_logic_link_result, i_comm_watchdog_expired,
    i_pid_feedback_limit_breach, i_setpoint_signal_lost, i_fault_alarm, i_pid_deviation_alarm,
    i_overload_warning, i_freq_threshold_exceeded, i_freq_setpoint_reached, i_running};
  wire logic wr = psel && penable && pwrite && pready;
  wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [3:0] fa_q, fb_q;
  logic       pa_q, pb_q, za_q, zb_q, run_q;
  logic [1:0] q_q;
  wire logic  sa = fa_q <= 4'ha && cv[fa_q];
  wire logic  sb = fb_q <= 4'ha && cv[fb_q];
  // Shadow holds only while no delay was ever set; timer state is not modelled
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
      {fa_q, fb_q, pa_q, pb_q, za_q, zb_q, q_q, run_q} <= {FSEL_A_RESET, FSEL_B_RESET, 4'h3, 2'h0, 1'b0};
    else
    begin
      q_q <= wr ? 2'h0 : q_q + {1'b0, q_q != 2'h3};
      if (psel && !penable)
        run_q <= i_running;
      if (wr && paddr == 8'h00 && !run_q)
        {fb_q, fa_q} <= {pwdata[11:8], pwdata[3:0]};
      if (wr && paddr == 8'h04)
        {pb_q, pa_q} <= {pwdata[8], pwdata[0]};
      if (wr && pwdata != 32'h0)
        za_q <= za_q && paddr != 8'h08 && paddr != 8'h0c;
      if (wr && pwdata != 32'h0)
        zb_q <= zb_q && paddr != 8'h10 && paddr != 8'h14;
    end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fsel_refused: assert property (psel && penable && pwrite && paddr == 8'h00 && run_q |-> pslverr)
    else $error("select write while running accepted");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_cause: assert property (pslverr |-> !mapped || (pwrite && paddr == 8'h00 && run_q))
    else $error("pslverr without cause");
  a_out_a_follow: assert property (za_q && q_q == 2'h3 |-> o_out_a == ($past(sa, 2) ^ pa_q))
    else $error("output a wrong");
  a_out_b_follow: assert property (zb_q && q_q == 2'h3 |-> o_out_b == ($past(sb, 2) ^ pb_q))
    else $error("output b wrong");
  c_refused: cover property (psel && penable && pslverr && i_running);
  c_out_rise: cover property ($rose(o_out_a));
  c_delayed_fall: cover property (!za_q && $fell(o_out_a));
endmodule : status_out_properties
bind status_out status_out_properties status_out_properties_inst (.*);
`default_nettype wire

// file: verif/status_out_tb_top.sv
// Self-checking bench for the status output block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module status_out_tb_top
  import status_out_pkg::*;
;
  logic        i_core_clk = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic        pready, pslverr, o_out_a, o_out_b, o_contact_a, o_contact_b;
  logic [10:0] cv = 0;
  logic [3:0]  fa, fb;
  logic [1:0]  pp;
  int          mismatches = 0, check_count = 0, i, n;

  always #25 i_core_clk = ~i_core_clk;

  // Short tick keeps the 0.1 s steps to ten cycles
  status_out #(.TICK_CYC(10)) status_out_inst (.*, .i_running(cv[0]), .i_freq_setpoint_reached(cv[1]),
    .i_freq_threshold_exceeded(cv[2]), .i_overload_warning(cv[3]), .i_pid_deviation_alarm(cv[4]),
    .i_fault_alarm(cv[5]), .i_setpoint_signal_lost(cv[6]), .i_pid_feedback_limit_breach(cv[7]),
    .i_comm_watchdog_expired(cv[8]), .i_logic_link_result(cv[9]), .i_fieldbus_comm_overload(cv[10]));
  relay_load relay_load_inst (.i_core_clk(i_core_clk), .i_coil_a(o_out_a), .i_coil_b(o_out_b),
    .o_contact_a(o_contact_a), .o_contact_b(o_contact_b));

  function automatic logic exp_out(logic [10:0] v, logic [3:0] c, logic p);
    return (c <= 4'ha && v[c]) ^ p;
  endfunction : exp_out

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1;
    do
    begin
      @(posedge i_core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge i_core_clk);
  endtask : xfer

  initial
  begin
    void'($urandom(89474));
    repeat (8) @(posedge i_core_clk);
    i_rst <= 0;
    @(posedge i_core_clk);
    xfer(0, 8'h00, 0);
    `CHK(rdata, 32'h1)
    for (i = 4; i <= 20; i += 4)
    begin
      xfer(0, 8'(i), 0);
      `CHK(rdata, 32'h0)
    end
    $display("reset test done");
    for (i = 0; i < 44; i++)
    begin
      fa = 4'(i % 11);
      fb = i < 22 ? 4'(10 - i % 11) : 4'($urandom % 16);
      pp = 2'($urandom);
      cv <= 0;
      xfer(1, 8'h00, {20'h0, fb, 4'h0, fa});
      xfer(1, 8'h04, {23'h0, pp[1], 7'h0, pp[0]});
      cv <= 11'($urandom);
      repeat (4) @(posedge i_core_clk);
      `CHK({o_out_b, o_out_a}, {exp_out(cv, fb, pp[1]), exp_out(cv, fa, pp[0])})
      `CHK(o_contact_a, o_out_a)
    end
    $display("function test done");
    cv <= 11'h1;
    xfer(1, 8'h00, 32'h0505);
    `CHK(rerr, 1'b1)
    xfer(0, 8'h00, 0);
    `CHK(rdata, {20'h0, fb, 4'h0, fa})
    xfer(0, 8'h40, 0);
    `CHK({rerr, rdata}, {1'b1, 32'h0})
    xfer(0, 8'h02, 0);
    `CHK({rerr, rdata}, {1'b1, 32'h0})
    $display("refusal test done");
    cv <= 0;
    xfer(1, 8'h00, 32'h5);
    xfer(1, 8'h04, 0);
    xfer(1, 8'h08, 32'd2000);
    xfer(0, 8'h08, 0);
    `CHK(rdata, 32'd1000)
    xfer(1, 8'h08, 32'd3);
    xfer(1, 8'h0c, 32'd2);
    cv <= 11'h20;
    repeat (15) @(posedge i_core_clk);
    cv <= 0;
    n = 0;
    repeat (40) @(posedge i_core_clk) n += int'(o_out_a !== 1'b0);
    `CHK(n, 0)
    cv <= 11'h20;
    n = 0;
    while (o_out_a !== 1'b1 && n < 60)
    begin
      @(posedge i_core_clk);
      n++;
    end
    `CHK(n >= 25 && n <= 34, 1'b1)
    xfer(0, 8'h18, 0);
    `CHK(rdata, 32'h5)
    cv <= 0;
    n = 0;
    while (o_out_a !== 1'b0 && n < 60)
    begin
      @(posedge i_core_clk);
      n++;
    end
    `CHK(n >= 15 && n <= 24, 1'b1)
    cv <= 11'h20;
    repeat (40) @(posedge i_core_clk);
    `CHK(o_out_a, 1'b1)
    cv <= 0;
    repeat (3) @(posedge i_core_clk);
    // Condition returns inside the off-delay
    cv <= 11'h20;
    n = 3;
    while (o_out_a !== 1'b0 && n < 60)
    begin
      @(posedge i_core_clk);
      n++;
    end
    `CHK(n >= 15 && n <= 24, 1'b1)
    xfer(1, 8'h14, 32'd7);
    xfer(0, 8'h14, 0);
    `CHK(rdata, 32'd7)
    $display("delay test done");
    stop_test();
  end
endmodule : status_out_tb_top
`default_nettype wire
